// >>> logic/rcr_regs.svh
// register offsets, fields, reset values and timing figures of the control block
`ifndef RCR_REGS_SVH
`define RCR_REGS_SVH

`define RCR_OFF_CFG 12'h000
`define RCR_OFF_STATE 12'h004
`define RCR_OFF_MEAS 12'h008
`define RCR_OFF_CMD 12'h00c
`define RCR_OFF_EVT 12'h010
`define RCR_OFF_STAT 12'h014
`define RCR_OFF_DAC 12'h018

`define RCR_CFG_ASG 1:0
`define RCR_CFG_MANUAL 2
`define RCR_CFG_SRC 5:4
`define RCR_CFG_LOCK 9:8
`define RCR_CFG_RELAY 13:12
`define RCR_CFG_VSEL 18:16
`define RCR_STATE_INST 3:0
`define RCR_STATE_ERR 4
`define RCR_MEAS_MANT 6:0
`define RCR_MEAS_LEAK 15:8
`define RCR_MEAS_INLET 23:16
`define RCR_MEAS_BACK 31:24

`define RCR_LOCK_RST 2'h1
`define RCR_RELAY_RST 2'h1
`define RCR_VSEL_RST 3'h2

`define RCR_CMD_START 0
`define RCR_CMD_STOP 1
`define RCR_CMD_VENT 2
`define RCR_CMD_CAL 3
`define RCR_CMD_RANGE 4
`define RCR_CMD_ZERO 5

`define RCR_ST_OFF 4'h0
`define RCR_ST_MEAS 4'h4
`define RCR_ST_FAULT 4'h7

`define RCR_VSEL_NOW 3'h0
`define RCR_VSEL_1S 3'h1
`define RCR_VSEL_1S5 3'h2
`define RCR_VSEL_2S 3'h3
`define RCR_VSEL_NONE 3'h4

`define RCR_MENU_BASIC 2'h0

`define RCR_MV_BASE 16'h03e8
`define RCR_MV_DECADE 16'h01f4
`define RCR_MV_MAX 16'h2710
`define RCR_MV_MANT_MIN_MANUAL 16'h0064
`define RCR_MV_MANT_MIN_AUTO 16'h03e8
`define RCR_MV_PER_TENTH 16'h0064

`define RCR_CLK_KHZ 100000
`define RCR_DEB_US 10
`define RCR_VENT_1_MS 1000
`define RCR_VENT_1S5_MS 1500
`define RCR_VENT_2_MS 2000

`endif

// >>> logic/rcr_pkg.sv
// types shared by the control block modules
package rcr_pkg;

    typedef enum logic [1:0] {
        asg_leak_rate,
        asg_leak_and_inlet,
        asg_inlet_and_backing
    } rcr_assign_type;

    typedef enum logic [1:0] {
        src_keyboard,
        src_serial,
        src_external
    } rcr_source_type;

    typedef struct packed {
        logic s1;
        logic s2;
        logic [15:0] cnt;
        logic lvl;
        logic rise;
    } rcr_flt_state_type;

    typedef struct packed {
        logic [13:0] mv;
    } rcr_dac_state_type;

    typedef struct packed {
        rcr_assign_type asg;
        logic manual;
        rcr_source_type src;
        logic [1:0] lock;
        logic [1:0] relay;
        logic [2:0] vsel;
        logic [3:0] inst;
        logic err_pend;
        logic [6:0] mant;
        logic [7:0] leak16;
        logic [7:0] inlet16;
        logic [7:0] back16;
        logic [5:0] evt;
        logic pwd_fresh;
        logic [27:0] hold_cnt;
        logic vent_done;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [6:0] cmd;
        logic menu_grant;
        logic menu_deny;
        logic zero_hold;
        logic trig3_en;
        logic trig3_lamp;
        logic ra_no;
        logic rb_no;
        logic [13:0] dac1;
        logic [13:0] dac4;
    } rcr_top_state_type;

endpackage : rcr_pkg

// >>> logic/rcr_inflt.sv
// synchroniser, debouncer and rising-edge detector for one control input
`timescale 1ns/1ns
module rcr_inflt #(
    parameter int unsigned DEB_CYC = 1000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic din,
    output logic lvl,
    output logic rise
);
    rcr_pkg::rcr_flt_state_type q;
    rcr_pkg::rcr_flt_state_type d;

    if (DEB_CYC < 1 || DEB_CYC > 65535) begin : g_bad_deb
        $error("rcr_inflt: DEB_CYC out of range");
    end

    always_comb begin
        d = q;
        d.s1 = din;
        d.s2 = q.s1;
        d.rise = 1'b0;
        // level must stay different for the full window before it is taken
        if (q.s2 != q.lvl) begin
            d.cnt = q.cnt + 16'h0001;
            if (q.cnt == 16'(DEB_CYC - 1)) begin
                d.lvl = q.s2;
                d.rise = q.s2;
                d.cnt = 16'h0000;
            end
        end else begin
            d.cnt = 16'h0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign lvl = q.lvl;
    assign rise = q.rise;
endmodule : rcr_inflt

// >>> logic/rcr_logdac.sv
// log code (1/16 decade steps) to recorder millivolts, 0.5 v per decade from 1 v
`timescale 1ns/1ns
`include "rcr_regs.svh"
module rcr_logdac (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] log16,
    input wire logic stair,
    output logic [13:0] mv
);
    rcr_pkg::rcr_dac_state_type q;
    rcr_pkg::rcr_dac_state_type d;
    logic [15:0] raw;

    always_comb begin
        // staircase drops the fraction so only whole decades move the output
        if (stair) begin
            raw = 16'({4'h0, log16[7:4]} * `RCR_MV_DECADE);
        end else begin
            raw = 16'(({8'h00, log16} * 16'h007d) >> 2);
        end
        raw = raw + `RCR_MV_BASE;
        if (raw > `RCR_MV_MAX) begin
            raw = `RCR_MV_MAX;
        end
        d.mv = raw[13:0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign mv = q.mv;
endmodule : rcr_logdac

// >>> logic/rcr_remote_ctrl.sv
// control source selection, key locking, external inputs, relays and recorder outputs
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ns
`include "rcr_regs.svh"
// Operation
// - leak-rate assignment: mantissa out1, exponent staircase out4
// - mantissa floor 0.1 v manual, 1 v auto
// - leak-and-inlet: both logarithmic, 0.5 v/decade
// - inlet-and-backing: both logarithmic, 0.5 v/decade
// - commands accepted from one selected source
// - lock level one honours every key
// - level two blocks cal, basic menu; password
// - level three also blocks range and zero
// - serial source ignores keys, rejects menu changes
// - external start rising edge starts measurement
// - external stop edge stops or acknowledges error
// - stop held past vent delay vents port
// - zero input high subtracts background
// - three relay modes: ready, fail, both
// - relay mode three disables threshold three
// - ready relay energised only while measuring
// - fail relay released only off or faulted
// - released closes nc pair, energised no
// - vent delay immediate, 1, 1.5, 2 s, none
module rcr_remote_ctrl #(
    parameter int unsigned DEB_CYC = `RCR_DEB_US * `RCR_CLK_KHZ / 1000,
    parameter int unsigned VENT_CYC_1 = `RCR_VENT_1_MS * `RCR_CLK_KHZ,
    parameter int unsigned VENT_CYC_1S5 = `RCR_VENT_1S5_MS * `RCR_CLK_KHZ,
    parameter int unsigned VENT_CYC_2 = `RCR_VENT_2_MS * `RCR_CLK_KHZ
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [5:0] key_press,
    input wire logic menu_req,
    input wire logic [1:0] menu_level,
    input wire logic pwd_entered,
    input wire logic ext_start,
    input wire logic ext_stop,
    input wire logic ext_zero,
    input wire logic trig3_hit,
    output logic start_cmd,
    output logic stop_cmd,
    output logic vent_cmd,
    output logic err_ack,
    output logic cal_cmd,
    output logic range_cmd,
    output logic zero_cmd,
    output logic menu_grant,
    output logic menu_deny,
    output logic zero_hold,
    output logic trig3_en,
    output logic trig3_lamp,
    output logic relay_a_no,
    output logic relay_a_nc,
    output logic relay_b_no,
    output logic relay_b_nc,
    output logic [13:0] dac1_mv,
    output logic [13:0] dac4_mv
);
    localparam rcr_pkg::rcr_top_state_type RST = '{
        asg: rcr_pkg::asg_leak_rate,
        src: rcr_pkg::src_keyboard,
        lock: `RCR_LOCK_RST,
        relay: `RCR_RELAY_RST,
        vsel: `RCR_VSEL_RST,
        trig3_en: 1'b1,
        default: '0
    };

    rcr_pkg::rcr_top_state_type q;
    rcr_pkg::rcr_top_state_type d;

    if (VENT_CYC_2 >= (1 << 28) || VENT_CYC_1 < 1 || VENT_CYC_1S5 < 1) begin : g_bad_vent
        $error("rcr_remote_ctrl: vent delay counts out of range");
    end

    logic st_lvl, st_rise, sp_lvl, sp_rise, zr_lvl;
    logic [13:0] dac_a_mv, dac_b_mv;
    logic [7:0] log_a, log_b;
    logic stair_b;
    logic wr, wr_cfg, wr_state, wr_meas;
    logic [5:0] cmdw, evt_clr, key_ok, req, key_mask;
    logic is_ext, is_ser, is_kbd, hold_vent, ready, fail_ok, rel_a;
    logic [27:0] vent_lim;
    logic [15:0] mant_mv;
    logic [31:0] cfg_word;

    // stop and zero are not edge-filtered alone: level timing needs the clean copy too
    // synchronise and debounce
    rcr_inflt #(.DEB_CYC(DEB_CYC)) u_flt_start (
        .pclk(pclk), .presetn(presetn), .din(ext_start), .lvl(st_lvl), .rise(st_rise));
    rcr_inflt #(.DEB_CYC(DEB_CYC)) u_flt_stop (
        .pclk(pclk), .presetn(presetn), .din(ext_stop), .lvl(sp_lvl), .rise(sp_rise));
    rcr_inflt #(.DEB_CYC(DEB_CYC)) u_flt_zero (
        .pclk(pclk), .presetn(presetn), .din(ext_zero), .lvl(zr_lvl), .rise());

    rcr_logdac u_dac_a (
        .pclk(pclk), .presetn(presetn), .log16(log_a), .stair(1'b0), .mv(dac_a_mv));
    rcr_logdac u_dac_b (
        .pclk(pclk), .presetn(presetn), .log16(log_b), .stair(stair_b), .mv(dac_b_mv));

    assign cfg_word = {13'h0000, q.vsel, 2'h0, q.relay, 2'h0, q.lock, 2'h0, q.src,
        1'b0, q.manual, q.asg};

    // bus write decode, kept apart so the command path can use it in the same cycle
    always_comb begin
        wr = psel & penable & q.pready & pwrite;
        wr_cfg = wr && (paddr == `RCR_OFF_CFG);
        wr_state = wr && (paddr == `RCR_OFF_STATE);
        wr_meas = wr && (paddr == `RCR_OFF_MEAS);
        cmdw = (wr && (paddr == `RCR_OFF_CMD)) ? pwdata[5:0] : 6'h00;
        evt_clr = (wr && (paddr == `RCR_OFF_EVT)) ? pwdata[5:0] : 6'h00;
    end

    // recorder channel routing
    always_comb begin
        stair_b = 1'b0;
        log_a = q.leak16;
        log_b = q.leak16;
        unique case (q.asg)
            rcr_pkg::asg_leak_rate: begin
                log_a = q.leak16;
                log_b = q.leak16;
                stair_b = 1'b1;
            end
            rcr_pkg::asg_leak_and_inlet: begin
                log_a = q.leak16;
                log_b = q.inlet16;
            end
            rcr_pkg::asg_inlet_and_backing: begin
                log_a = q.inlet16;
                log_b = q.back16;
            end
        endcase
        mant_mv = 16'({9'h000, q.mant} * `RCR_MV_PER_TENTH);
        if (q.manual && mant_mv < `RCR_MV_MANT_MIN_MANUAL) begin
            mant_mv = `RCR_MV_MANT_MIN_MANUAL;
        end else if (!q.manual && mant_mv < `RCR_MV_MANT_MIN_AUTO) begin
            mant_mv = `RCR_MV_MANT_MIN_AUTO;
        end
        if (mant_mv > `RCR_MV_MAX) begin
            mant_mv = `RCR_MV_MAX;
        end
    end

    always_comb begin
        d = q;
        d.pready = psel & ~penable;
        d.pslverr = 1'b0;
        d.cmd = 7'h00;
        d.menu_grant = 1'b0;
        d.menu_deny = 1'b0;
        is_ext = (q.src == rcr_pkg::src_external);
        is_ser = (q.src == rcr_pkg::src_serial);
        is_kbd = (q.src == rcr_pkg::src_keyboard);
        hold_vent = 1'b0;

        key_mask = 6'h3f;
        if (q.lock == 2'h2) begin
            key_mask[`RCR_CMD_CAL] = 1'b0;
        end
        if (q.lock == 2'h3) begin
            key_mask[`RCR_CMD_CAL] = 1'b0;
            key_mask[`RCR_CMD_RANGE] = 1'b0;
            key_mask[`RCR_CMD_ZERO] = 1'b0;
        end
        key_ok = is_kbd ? (key_press & key_mask) : 6'h00;

        req = key_ok | (is_ser ? cmdw : 6'h00);
        if (is_ext) begin
            req[`RCR_CMD_START] = st_rise;
            req[`RCR_CMD_STOP] = sp_rise;
        end

        unique case (q.vsel)
            `RCR_VSEL_1S: vent_lim = 28'(VENT_CYC_1);
            `RCR_VSEL_1S5: vent_lim = 28'(VENT_CYC_1S5);
            `RCR_VSEL_2S: vent_lim = 28'(VENT_CYC_2);
            default: vent_lim = 28'h0000000;
        endcase
        if (is_ext && sp_lvl) begin
            if (!q.vent_done) begin
                d.hold_cnt = q.hold_cnt + 28'h0000001;
                if (q.vsel == `RCR_VSEL_NOW ||
                    (q.vsel != `RCR_VSEL_NONE && q.hold_cnt == vent_lim)) begin
                    hold_vent = 1'b1;
                    d.vent_done = 1'b1;
                end
            end
        end else begin
            d.hold_cnt = 28'h0000000;
            d.vent_done = 1'b0;
        end

        // a stop while an error is pending only acknowledges it
        d.cmd[`RCR_CMD_START] = req[`RCR_CMD_START];
        d.cmd[`RCR_CMD_STOP] = req[`RCR_CMD_STOP] & ~q.err_pend;
        d.cmd[`RCR_CMD_VENT] = req[`RCR_CMD_VENT] | hold_vent;
        d.cmd[`RCR_CMD_CAL] = req[`RCR_CMD_CAL];
        d.cmd[`RCR_CMD_RANGE] = req[`RCR_CMD_RANGE];
        d.cmd[`RCR_CMD_ZERO] = req[`RCR_CMD_ZERO];
        d.cmd[6] = req[`RCR_CMD_STOP] & q.err_pend;
        if (d.cmd[6]) begin
            d.err_pend = 1'b0;
        end
        d.zero_hold = is_ext & zr_lvl;

        if (menu_req) begin
            if (is_ser || (q.lock != 2'h1 && menu_level == `RCR_MENU_BASIC)) begin
                d.menu_deny = 1'b1;
            end else if (q.lock == 2'h1) begin
                d.menu_grant = 1'b1;
            end else if (q.pwd_fresh) begin
                d.menu_grant = 1'b1;
                d.pwd_fresh = 1'b0;
            end else begin
                d.menu_deny = 1'b1;
            end
        end

        ready = (q.inst == `RCR_ST_MEAS);
        fail_ok = (q.inst != `RCR_ST_OFF) && (q.inst != `RCR_ST_FAULT);
        rel_a = (q.relay == 2'h2) ? fail_ok : ready;
        d.ra_no = rel_a;
        d.rb_no = (q.relay == 2'h3) & fail_ok;
        d.trig3_en = (q.relay != 2'h3);
        d.trig3_lamp = trig3_hit & (q.relay != 2'h3);

        d.dac1 = (q.asg == rcr_pkg::asg_leak_rate) ? mant_mv[13:0] : dac_a_mv;
        d.dac4 = dac_b_mv;

        if (wr_cfg) begin
            unique case (pwdata[`RCR_CFG_ASG])
                2'h0: d.asg = rcr_pkg::asg_leak_rate;
                2'h1: d.asg = rcr_pkg::asg_leak_and_inlet;
                2'h2: d.asg = rcr_pkg::asg_inlet_and_backing;
                default: ;
            endcase
            unique case (pwdata[`RCR_CFG_SRC])
                2'h0: d.src = rcr_pkg::src_keyboard;
                2'h1: d.src = rcr_pkg::src_serial;
                2'h2: d.src = rcr_pkg::src_external;
                default: ;
            endcase
            d.manual = pwdata[`RCR_CFG_MANUAL];
            // level zero is not a lock level; the old one stays
            if (pwdata[`RCR_CFG_LOCK] != 2'h0) begin
                d.lock = pwdata[`RCR_CFG_LOCK];
                d.pwd_fresh = 1'b0;
            end
            if (pwdata[`RCR_CFG_RELAY] != 2'h0) begin
                d.relay = pwdata[`RCR_CFG_RELAY];
            end
            if (pwdata[`RCR_CFG_VSEL] <= `RCR_VSEL_NONE) begin
                d.vsel = pwdata[`RCR_CFG_VSEL];
            end
        end
        if (wr_state) begin
            d.inst = pwdata[`RCR_STATE_INST];
            // software raising an error wins over a same-cycle acknowledge
            d.err_pend = pwdata[`RCR_STATE_ERR] | d.err_pend;
        end
        if (wr_meas) begin
            d.mant = pwdata[`RCR_MEAS_MANT];
            d.leak16 = pwdata[`RCR_MEAS_LEAK];
            d.inlet16 = pwdata[`RCR_MEAS_INLET];
            d.back16 = pwdata[`RCR_MEAS_BACK];
        end
        if (pwd_entered) begin
            d.pwd_fresh = 1'b1;
        end
        // sticky events: a new event beats its clear
        d.evt = (q.evt & ~evt_clr) | {|(key_press & ~key_ok), d.menu_deny, d.cmd[6],
            d.cmd[`RCR_CMD_VENT], d.cmd[`RCR_CMD_STOP], d.cmd[`RCR_CMD_START]};

        if (psel & ~penable) begin
            d.prdata = 32'h00000000;
            unique case (paddr)
                `RCR_OFF_CFG: d.prdata = cfg_word;
                `RCR_OFF_STATE: d.prdata = {27'h0000000, q.err_pend, q.inst};
                `RCR_OFF_MEAS: d.prdata = {q.back16, q.inlet16, q.leak16, 1'b0, q.mant};
                `RCR_OFF_CMD: d.prdata = 32'h00000000;
                `RCR_OFF_EVT: d.prdata = {26'h0000000, q.evt};
                `RCR_OFF_STAT: d.prdata = {26'h0000000, q.pwd_fresh, st_lvl, sp_lvl,
                    q.rb_no, q.ra_no, zr_lvl};
                `RCR_OFF_DAC: d.prdata = {2'h0, q.dac4, 2'h0, q.dac1};
                default: d.pslverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= RST;
        end else begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign start_cmd = q.cmd[`RCR_CMD_START];
    assign stop_cmd = q.cmd[`RCR_CMD_STOP];
    assign vent_cmd = q.cmd[`RCR_CMD_VENT];
    assign cal_cmd = q.cmd[`RCR_CMD_CAL];
    assign range_cmd = q.cmd[`RCR_CMD_RANGE];
    assign zero_cmd = q.cmd[`RCR_CMD_ZERO];
    assign err_ack = q.cmd[6];
    assign menu_grant = q.menu_grant;
    assign menu_deny = q.menu_deny;
    assign zero_hold = q.zero_hold;
    assign trig3_en = q.trig3_en;
    assign trig3_lamp = q.trig3_lamp;
    assign relay_a_no = q.ra_no;
    assign relay_a_nc = ~q.ra_no;
    assign relay_b_no = q.rb_no;
    assign relay_b_nc = ~q.rb_no;
    assign dac1_mv = q.dac1;
    assign dac4_mv = q.dac4;

    AST_READY_MEAS: assert property (
        @(posedge pclk) disable iff (!presetn)
        (q.relay == 2'h1) ##1 (q.relay == 2'h1) |-> relay_a_no == ($past(q.inst) == `RCR_ST_MEAS))
        else $error("ready relay does not follow measurement state");
    AST_FAIL_FAULT: assert property (
        @(posedge pclk) disable iff (!presetn)
        (q.relay == 2'h2 && q.inst == `RCR_ST_FAULT) |=> !relay_a_no)
        else $error("fail relay energised while faulted");
    AST_FAIL_ON: assert property (
        @(posedge pclk) disable iff (!presetn)
        (q.relay == 2'h3 && q.inst == `RCR_ST_MEAS) |=> relay_a_no && relay_b_no)
        else $error("mode three relays wrong while measuring");
    AST_CONTACTS: assert property (
        @(posedge pclk) disable iff (!presetn)
        relay_a_no != relay_a_nc && relay_b_no != relay_b_nc)
        else $error("contact pair both open or both closed");
    AST_TRIG3: assert property (
        @(posedge pclk) disable iff (!presetn)
        (q.relay == 2'h3) |=> !trig3_lamp && !trig3_en)
        else $error("threshold three active in relay mode three");
    AST_LOCK1_KEY: assert property (
        @(posedge pclk) disable iff (!presetn)
        (is_kbd && q.lock == 2'h1 && key_press[`RCR_CMD_CAL]) |=> cal_cmd)
        else $error("calibrate key lost at lock level one");
    AST_LOCK2_CAL: assert property (
        @(posedge pclk) disable iff (!presetn)
        (is_kbd && q.lock == 2'h2) |=> !cal_cmd)
        else $error("calibrate honoured at lock level two");
    AST_LOCK3_KEYS: assert property (
        @(posedge pclk) disable iff (!presetn)
        (is_kbd && q.lock == 2'h3) |=> !cal_cmd && !range_cmd && !zero_cmd)
        else $error("locked key honoured at lock level three");
    AST_SERIAL_KEYS: assert property (
        @(posedge pclk) disable iff (!presetn)
        (is_ser && cmdw == 6'h00 && menu_req) |=> !start_cmd && !cal_cmd && menu_deny)
        else $error("serial source let a key or menu change through");
    AST_EXT_GATE: assert property (
        @(posedge pclk) disable iff (!presetn)
        !is_ext |=> !zero_hold)
        else $error("zero level passed without external source");
    AST_NO_VENT: assert property (
        @(posedge pclk) disable iff (!presetn)
        (is_ext && q.vsel == `RCR_VSEL_NONE) |=> !vent_cmd)
        else $error("vent issued with venting disabled");
    AST_MANT_AUTO: assert property (
        @(posedge pclk) disable iff (!presetn)
        (q.asg == rcr_pkg::asg_leak_rate && !q.manual)[*2] |-> dac1_mv >= 14'h03e8)
        else $error("mantissa below 1 v in automatic ranging");
    AST_STAIR: assert property (
        @(posedge pclk) disable iff (!presetn)
        (q.asg == rcr_pkg::asg_leak_rate)[*3] |-> (dac4_mv % 14'h01f4) == 14'h0000)
        else $error("exponent output not on a half-volt step");

    CVR_EXT_START: cover property (@(posedge pclk) disable iff (!presetn) is_ext && start_cmd);
    CVR_HOLD_VENT: cover property (@(posedge pclk) disable iff (!presetn) hold_vent);
    CVR_ERR_ACK: cover property (@(posedge pclk) disable iff (!presetn) err_ack);
    CVR_PWD_MENU: cover property (@(posedge pclk) disable iff (!presetn)
        q.lock == 2'h3 && menu_grant);
endmodule : rcr_remote_ctrl

// >>> sim/rcr_ctrl_model.sv
// external controller model driving the start, stop and zero control inputs
`timescale 1ns/1ns
module rcr_ctrl_model (
    input wire logic pclk,
    output logic ext_start,
    output logic ext_stop,
    output logic ext_zero
);
    // all idle low, as an unconnected controller
    initial begin
        ext_start = 1'b0;
        ext_stop = 1'b0;
        ext_zero = 1'b0;
    end

    task automatic press(input int which, input int cyc);
        @(posedge pclk);
        if (which == 0)
            ext_start <= 1'b1;
        else if (which == 1)
            ext_stop <= 1'b1;
        else
            ext_zero <= 1'b1;
        repeat (cyc) @(posedge pclk);
        ext_start <= 1'b0;
        ext_stop <= 1'b0;
        ext_zero <= 1'b0;
    endtask : press
endmodule : rcr_ctrl_model

// >>> sim/test_rcr_remote_ctrl.sv
// self-checking testbench of the remote control and relay block
`timescale 1ns/1ns
module test_rcr_remote_ctrl;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, q;
    logic pready, pslverr, last_err, start_cmd, stop_cmd, vent_cmd, trig3_en;
    logic relay_a_no, relay_a_nc, relay_b_no, relay_b_nc, zero_hold, trig3_lamp;
    logic menu_grant, menu_deny;
    logic menu_req = 1'b0;
    logic [1:0] menu_level = 2'h0;
    logic pwd_entered = 1'b0;
    logic trig3_hit = 1'b0;
    logic [13:0] dac1_mv, dac4_mv;
    logic [5:0] key_press = 6'h00;
    logic ext_start, ext_stop, ext_zero;
    int errors = 0;
    int check_count = 0;
    int n_st = 0;
    int n_sp = 0;
    int n_vt = 0;
    int b_st, b_sp, b_vt;
    // row: relay mode, instrument state, relay a energised, relay b energised
    localparam logic [7:0] ROWS [8] = '{8'h52, 8'h48, 8'h86, 8'h9c, 8'hd3, 8'hc0, 8'hd9, 8'ha2};

    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        n_st <= n_st + int'(start_cmd === 1'b1);
        n_sp <= n_sp + int'(stop_cmd === 1'b1);
        n_vt <= n_vt + int'(vent_cmd === 1'b1);
    end

    rcr_remote_ctrl #(.DEB_CYC(4), .VENT_CYC_1(20), .VENT_CYC_1S5(30), .VENT_CYC_2(40))
        rcr_remote_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .key_press(key_press), .menu_req(menu_req), .menu_level(menu_level),
        .pwd_entered(pwd_entered), .ext_start(ext_start), .ext_stop(ext_stop),
        .ext_zero(ext_zero), .trig3_hit(trig3_hit), .start_cmd(start_cmd), .stop_cmd(stop_cmd),
        .vent_cmd(vent_cmd), .err_ack(), .cal_cmd(), .range_cmd(), .zero_cmd(),
        .menu_grant(menu_grant), .menu_deny(menu_deny), .zero_hold(zero_hold),
        .trig3_en(trig3_en), .trig3_lamp(trig3_lamp), .relay_a_no(relay_a_no),
        .relay_a_nc(relay_a_nc), .relay_b_no(relay_b_no), .relay_b_nc(relay_b_nc),
        .dac1_mv(dac1_mv), .dac4_mv(dac4_mv));
    rcr_ctrl_model rcr_ctrl_model_inst (.pclk(pclk), .ext_start(ext_start),
        .ext_stop(ext_stop), .ext_zero(ext_zero));

    task automatic summarize();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    // request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge so a following call never re-drives psel in the same step
        @(posedge pclk);
        if (n >= 20) begin
            errors++;
            summarize();
        end
    endtask : apb

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("relay_a_nc", 1, relay_a_nc);
        chk("dac1", 1000, dac1_mv);
        chk("dac4", 1000, dac4_mv);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, 12'h000, {18'h0, ROWS[i][7:6], 12'h000}, q);
            apb(1'b1, 12'h004, {28'h0, ROWS[i][5:2]}, q);
            repeat (2) @(posedge pclk);
            chk("relay_a", ROWS[i][1], relay_a_no);
            chk("relay_b", ROWS[i][0], relay_b_no);
            chk("relay_a_nc", !ROWS[i][1], relay_a_nc);
            chk("trig3_en", ROWS[i][7:6] != 2'h3, trig3_en);
        end
        apb(1'b1, 12'h008, 32'h30102005, q);
        apb(1'b0, 12'h008, 32'h0, q);
        chk("meas", 32'h30102005, q);
        apb(1'b0, 12'h01c, 32'h0, q);
        chk("pslverr", 1, last_err);
        apb(1'b1, 12'h000, 32'h00001004, q);
        repeat (3) @(posedge pclk);
        chk("dac1", 500, dac1_mv);
        chk("dac4", 2000, dac4_mv);
        apb(1'b1, 12'h000, 32'h00001001, q);
        repeat (3) @(posedge pclk);
        chk("dac1", 2000, dac1_mv);
        chk("dac4", 1500, dac4_mv);
        apb(1'b1, 12'h000, 32'h00001002, q);
        repeat (3) @(posedge pclk);
        chk("dac1", 1500, dac1_mv);
        chk("dac4", 2500, dac4_mv);
        // keyboard source at lock two: start key honoured, cal key and external edge not
        apb(1'b1, 12'h000, 32'h00011200, q);
        b_st = n_st;
        key_press <= 6'h09;
        @(posedge pclk);
        key_press <= 6'h00;
        rcr_ctrl_model_inst.press(0, 12);
        repeat (12) @(posedge pclk);
        chk("start_cnt", 1, n_st - b_st);
        apb(1'b1, 12'h000, 32'h00011020, q);
        b_st = n_st;
        rcr_ctrl_model_inst.press(0, 12);
        repeat (12) @(posedge pclk);
        chk("start_cnt", 1, n_st - b_st);
        b_sp = n_sp;
        b_vt = n_vt;
        rcr_ctrl_model_inst.press(1, 40);
        repeat (12) @(posedge pclk);
        chk("stop_cnt", 1, n_sp - b_sp);
        chk("vent_cnt", 1, n_vt - b_vt);
        fork
            rcr_ctrl_model_inst.press(2, 20);
            begin
                repeat (12) @(posedge pclk);
                chk("zero_hold", 1, zero_hold);
            end
        join
        repeat (12) @(posedge pclk);
        chk("zero_hold", 0, zero_hold);
        apb(1'b1, 12'h000, 32'h00041020, q);
        apb(1'b1, 12'h004, 32'h00000014, q);
        b_sp = n_sp;
        b_vt = n_vt;
        rcr_ctrl_model_inst.press(1, 30);
        repeat (12) @(posedge pclk);
        chk("stop_cnt", 0, n_sp - b_sp);
        chk("vent_cnt", 0, n_vt - b_vt);
        apb(1'b0, 12'h010, 32'h0, q);
        chk("evt_ack", 1, q[3]);
        trig3_hit <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("trig3_lamp", 1, trig3_lamp);
        apb(1'b1, 12'h000, 32'h00013020, q);
        repeat (2) @(posedge pclk);
        chk("trig3_lamp", 0, trig3_lamp);
        chk("relay_b_nc", 0, relay_b_nc);
        apb(1'b1, 12'h000, 32'h00013310, q);
        menu_level <= 2'h1;
        menu_req <= 1'b1;
        @(posedge pclk);
        menu_req <= 1'b0;
        @(posedge pclk);
        chk("menu_deny", 1, menu_deny);
        apb(1'b1, 12'h000, 32'h00013300, q);
        pwd_entered <= 1'b1;
        @(posedge pclk);
        pwd_entered <= 1'b0;
        menu_req <= 1'b1;
        @(posedge pclk);
        menu_req <= 1'b0;
        @(posedge pclk);
        chk("menu_grant", 1, menu_grant);
        summarize();
    end
endmodule : test_rcr_remote_ctrl
